// >>> ccs_pkg.sv
// Constants, field layouts and carrier types for the coil circuit supervisor
package ccs_pkg;
    localparam int NUM_COILS = 6;
    localparam int BASE_COILS = 3;
    localparam int NUM_INPUTS = 22;
    localparam int DLY_W = 13;
    localparam int ADDR_W = 8;
    localparam int DIV_W = 18;
    localparam int SLOT_W = 7;
    localparam int PCNT_W = 16;

    // Timing: the delay setting counts in 10 ms steps
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_MS = 10;
    localparam int PULSE_MS = 100;
    localparam int PERIOD_MS = 1000;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PULSE_TICKS = PULSE_MS / TICK_MS;
    localparam int PERIOD_TICKS = PERIOD_MS / TICK_MS;

    // Mode encoding of a coil
    localparam logic [1:0] MODE_NONE = 2'h0;
    localparam logic [1:0] MODE_ONE = 2'h1;
    localparam logic [1:0] MODE_TWO = 2'h2;
    localparam logic [DLY_W-1:0] DLY_RST = 13'h0014;

    // Input pairs, zero based: bit k of the input vector is input k+1
    localparam int PAIR_A [NUM_COILS] = '{2, 5, 8, 16, 18, 20};
    localparam int PAIR_B [NUM_COILS] = '{3, 6, 9, 17, 19, 21};

    // Register map
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_EVENT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_INPUTS = 8'h08;
    localparam logic [ADDR_W-1:0] REG_PCOUNT = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_CFG0 = 8'h10;
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_DLY_LSB = 8;
    localparam int ST_DISC_LSB = 8;
    localparam int ST_PULSE_BIT = 16;
    localparam int ST_MODEL_BIT = 17;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [DLY_W-1:0] delay;
        logic [1:0] mode;
    } ccs_cfg_t;

    localparam ccs_cfg_t CFG_RST = '{delay: DLY_RST, mode: MODE_NONE};

    typedef struct packed {
        logic tick;
        logic pulse;
        logic sample;
    } ccs_time_t;
endpackage

// >>> ccs_timebase.sv
// Tick, test pulse window and sample strobe generator
`timescale 1ns/1ps
`default_nettype none
module ccs_timebase #(
    parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    output ccs_pkg::ccs_time_t tb
);
    import ccs_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [SLOT_W-1:0] slot;
        ccs_time_t tb;
    } ccs_tb_state_t;

    ccs_tb_state_t s_r;
    ccs_tb_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tb.tick = 1'b0;
        s_nxt.tb.sample = 1'b0;
        if (s_r.div == DIV_W'(TICK_CYCLES - 1)) begin
            s_nxt.div = '0;
            s_nxt.tb.tick = 1'b1;
            if (s_r.slot == SLOT_W'(PERIOD_TICKS - 1)) begin
                s_nxt.slot = '0;
            end else begin
                s_nxt.slot = s_r.slot + 1'b1;
            end
            // 100 ms of every second, inputs judged inside the window
            s_nxt.tb.pulse = s_nxt.slot < SLOT_W'(PULSE_TICKS);
            s_nxt.tb.sample = s_nxt.slot == SLOT_W'(PULSE_TICKS - 1);
        end else begin
            s_nxt.div = s_r.div + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.tb.pulse <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tb = s_r.tb;
endmodule
`default_nettype wire

// >>> ccs_channel.sv
// One coil supervision channel: continuity check, delay timer, failure flag
`timescale 1ns/1ps
`default_nettype none
module ccs_channel (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ccs_pkg::ccs_time_t tb,
    input wire ccs_pkg::ccs_cfg_t cfg,
    input wire logic in_a,
    input wire logic in_b,
    output logic disc,
    output logic fail,
    output logic evt
);
    import ccs_pkg::*;

    typedef struct packed {
        logic disc;
        logic [DLY_W-1:0] cnt;
        logic fail;
        logic evt;
    } ccs_ch_state_t;

    ccs_ch_state_t s_r;
    ccs_ch_state_t s_nxt;
    logic ok;

    always_comb begin
        s_nxt = s_r;
        // Two-state: XOR; supply loss drops both inputs and fails here
        ok = (cfg.mode == MODE_TWO) ? (in_a ^ in_b) : in_a;
        if (cfg.mode != MODE_ONE && cfg.mode != MODE_TWO) begin
            s_nxt.disc = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.fail = 1'b0;
        end else if (tb.sample) begin
            if (ok) begin
                s_nxt.disc = 1'b0;
                s_nxt.cnt = '0;
                s_nxt.fail = 1'b0;
            end else begin
                s_nxt.disc = 1'b1;
            end
        end else if (tb.tick && s_r.disc) begin
            // A discordance seen at one sample keeps counting until the next, so it reaches any delay of 99 ticks or less
            if (s_r.cnt != '1) begin
                s_nxt.cnt = s_r.cnt + 1'b1;
            end
            if (s_nxt.cnt >= cfg.delay) begin
                s_nxt.fail = 1'b1;
            end
        end
        s_nxt.evt = s_nxt.fail != s_r.fail;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign disc = s_r.disc;
    assign fail = s_r.fail;
    assign evt = s_r.evt;
endmodule
`default_nettype wire

// >>> ccs_top.sv
// Coil circuit supervisor top: AXI4-Lite registers, channels, plain inputs
`timescale 1ns/1ps
`default_nettype none
module ccs_top #(
    parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic model_six,
    input wire logic [ccs_pkg::NUM_INPUTS-1:0] status_in,
    input wire logic [ccs_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ccs_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [ccs_pkg::NUM_COILS-1:0] coil_circuit_failure_flag,
    output logic [ccs_pkg::NUM_COILS-1:0] coil_event,
    output logic test_pulse,
    output logic [ccs_pkg::NUM_INPUTS-1:0] status_plain
);
    import ccs_pkg::*;

    // Bus handshake state, coil settings, sticky events and the variant strap
    typedef struct packed {
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        ccs_cfg_t [NUM_COILS-1:0] cfg;
        logic [NUM_COILS-1:0] evt;
        logic [PCNT_W-1:0] pcount;
        logic model;
        logic model_done;
        logic [NUM_INPUTS-1:0] plain;
    } ccs_top_state_t;

    ccs_top_state_t s_r;
    ccs_top_state_t s_nxt;

    ccs_time_t tb;
    ccs_cfg_t [NUM_COILS-1:0] eff_cfg;
    logic [NUM_COILS-1:0] ch_disc;
    logic [NUM_COILS-1:0] ch_fail;
    logic [NUM_COILS-1:0] ch_evt;
    logic [NUM_INPUTS-1:0] sup_mask;

    // Byte-lane merge of a write into an existing word
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Packs one coil's settings into its register layout
    function automatic logic [31:0] cfg_word(input ccs_cfg_t c);
        logic [31:0] w;
        w = '0;
        w[CFG_MODE_LSB +: 2] = c.mode;
        w[CFG_DLY_LSB +: DLY_W] = c.delay;
        return w;
    endfunction

    // Unpacks a register word; bits outside the fields are dropped
    function automatic ccs_cfg_t word_cfg(input logic [31:0] w);
        ccs_cfg_t c;
        c.mode = w[CFG_MODE_LSB +: 2];
        c.delay = w[CFG_DLY_LSB +: DLY_W];
        return c;
    endfunction

    // Configuration register index, or NUM_COILS when the address is not one
    function automatic int cfg_index(input logic [ADDR_W-1:0] a);
        int idx;
        idx = NUM_COILS;
        for (int i = 0; i < NUM_COILS; i++) begin
            if (a == REG_CFG0 + ADDR_W'(4 * i)) begin
                idx = i;
            end
        end
        return idx;
    endfunction

    // Modes 0 and 3 both mean no supervision
    function automatic logic mode_on(input logic [1:0] m);
        return m == MODE_ONE || m == MODE_TWO;
    endfunction

    // Registers that answer OKAY but ignore write data
    function automatic logic ro_reg(input logic [ADDR_W-1:0] a);
        return a == REG_STATUS || a == REG_INPUTS || a == REG_PCOUNT;
    endfunction

    // One shared timebase keeps every channel judging in the same window
    ccs_timebase #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timebase (
        .aclk(aclk),
        .aresetn(aresetn),
        .tb(tb)
    );

    // Coils above the base set exist only on the six-coil variant
    always_comb begin
        for (int i = 0; i < NUM_COILS; i++) begin
            eff_cfg[i] = s_r.cfg[i];
            if (i >= BASE_COILS && !s_r.model) begin
                eff_cfg[i].mode = MODE_NONE;
            end
        end
    end

    // Each channel owns its state, settings and input pair
    for (genvar g = 0; g < NUM_COILS; g++) begin : g_ch
        ccs_channel u_ch (
            .aclk(aclk),
            .aresetn(aresetn),
            .tb(tb),
            .cfg(eff_cfg[g]),
            .in_a(status_in[PAIR_A[g]]),
            .in_b(status_in[PAIR_B[g]]),
            .disc(ch_disc[g]),
            .fail(ch_fail[g]),
            .evt(ch_evt[g])
        );
    end

    // Inputs claimed by supervision are hidden from the plain status view
    always_comb begin
        sup_mask = '0;
        for (int i = 0; i < NUM_COILS; i++) begin
            if (mode_on(eff_cfg[i].mode)) begin
                sup_mask[PAIR_A[i]] = 1'b1;
            end
            if (eff_cfg[i].mode == MODE_TWO) begin
                sup_mask[PAIR_B[i]] = 1'b1;
            end
        end
    end

    always_comb begin
        int wi;
        int ri;
        s_nxt = s_r;
        wi = cfg_index(s_r.aw_addr);
        ri = cfg_index(s_axi_araddr);

        // Variant strap is taken once, on the first edge after reset
        if (!s_r.model_done) begin
            s_nxt.model = model_six;
            s_nxt.model_done = 1'b1;
        end

        // Plain view lags status_in by one cycle, like every other register
        s_nxt.plain = status_in & ~sup_mask;

        // Counts sample strobes so software can see the pulse running
        if (tb.sample) begin
            s_nxt.pcount = s_r.pcount + 1'b1;
        end

        // Sticky change events; a new event beats a clear in the same cycle
        s_nxt.evt = s_r.evt | ch_evt;

        // Address and data are parked until both halves have arrived
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_held = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_held = 1'b1;
            s_nxt.w_data = s_axi_wdata;
            s_nxt.w_strb = s_axi_wstrb;
        end


        // Commit one cycle after the later half; the answer waits in bvalid
        if (s_r.aw_held && s_r.w_held) begin
            s_nxt.aw_held = 1'b0;
            s_nxt.w_held = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            if (wi < NUM_COILS) begin
                s_nxt.cfg[wi] = word_cfg(wmerge(cfg_word(s_r.cfg[wi]), s_r.w_data,
                                                s_r.w_strb));
            end else if (s_r.aw_addr == REG_EVENT) begin
                if (s_r.w_strb[0]) begin
                    s_nxt.evt = (s_r.evt & ~s_r.w_data[NUM_COILS-1:0]) | ch_evt;
                end
            end else if (!ro_reg(s_r.aw_addr)) begin
                s_nxt.bresp = RESP_SLVERR;
            end
        end else if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end


        // Read word is frozen at the address edge, so a slow rready sees no change
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = '0;
            if (ri < NUM_COILS) begin
                s_nxt.rdata = cfg_word(s_r.cfg[ri]);
            end else begin
                unique case (s_axi_araddr)
                    REG_STATUS: begin
                        s_nxt.rdata[NUM_COILS-1:0] = ch_fail;
                        s_nxt.rdata[ST_DISC_LSB +: NUM_COILS] = ch_disc;
                        s_nxt.rdata[ST_PULSE_BIT] = tb.pulse;
                        s_nxt.rdata[ST_MODEL_BIT] = s_r.model;
                    end
                    REG_EVENT: begin
                        s_nxt.rdata[NUM_COILS-1:0] = s_r.evt;
                    end
                    REG_INPUTS: begin
                        s_nxt.rdata[NUM_INPUTS-1:0] = status_in;
                    end
                    REG_PCOUNT: begin
                        s_nxt.rdata[PCNT_W-1:0] = s_r.pcount;
                    end
                    default: begin
                        s_nxt.rresp = RESP_SLVERR;
                    end
                endcase
            end
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            // Settings start as mode none with a 0.2 s delay
            s_r.cfg <= {NUM_COILS{CFG_RST}};
        end else begin
            s_r <= s_nxt;
        end
    end

    // One write and one read in flight; new requests wait for the answer
    assign s_axi_awready = !s_r.aw_held && !s_r.bvalid;
    assign s_axi_wready = !s_r.w_held && !s_r.bvalid;
    assign s_axi_arready = !s_r.rvalid;

    // Responses come straight from the state register
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;

    // Flags and events leave from the channel flops, not from the read path
    assign coil_circuit_failure_flag = ch_fail;
    assign coil_event = ch_evt;
    // Injection window for the drive stage that sits outside this block
    assign test_pulse = tb.pulse;
    assign status_plain = s_r.plain;
endmodule
`default_nettype wire

// >>> ccs_monitor.sv
// Port-level assertions for the coil circuit supervisor, bound into the top
`timescale 1ns/1ps
`default_nettype none
module ccs_monitor #(
    parameter int TICK_CYCLES = ccs_pkg::TICK_CYCLES_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic model_six,
    input wire logic [ccs_pkg::NUM_INPUTS-1:0] status_in,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ccs_pkg::NUM_COILS-1:0] coil_circuit_failure_flag,
    input wire logic [ccs_pkg::NUM_COILS-1:0] coil_event,
    input wire logic test_pulse,
    input wire logic [ccs_pkg::NUM_INPUTS-1:0] status_plain
);
    import ccs_pkg::*;
    localparam int PULSE_CYC = PULSE_TICKS * TICK_CYCLES;
    localparam int PERIOD_CYC = PERIOD_TICKS * TICK_CYCLES;
    logic tp_q;
    logic tp_seen;
    int tp_cnt;
    // Reset value 1: the window is open during reset, so release is not a rise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tp_q <= 1'b1;
            tp_seen <= 1'b0;
            tp_cnt <= 0;
        end else begin
            tp_q <= test_pulse;
            if (test_pulse && !tp_q) begin
                tp_seen <= 1'b1;
                tp_cnt <= 1;
            end else begin
                tp_cnt <= tp_cnt + 1;
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_bwait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_rwait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    property p_evt;
        coil_event == (coil_circuit_failure_flag ^ $past(coil_circuit_failure_flag));
    endproperty
    a_evt: assert property (p_evt) else $error("event pulse does not match flag change");
    property p_pulse_len;
        (tp_seen && tp_q && !test_pulse) |-> tp_cnt == PULSE_CYC;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("test pulse length wrong");
    property p_period;
        (tp_seen && !tp_q && test_pulse) |-> tp_cnt == PERIOD_CYC;
    endproperty
    a_period: assert property (p_period) else $error("test pulse period wrong");
    property p_bhold;
        s_bwait |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped early");
    property p_rhold;
        s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data dropped early");
    property p_wbusy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wbusy: assert property (p_wbusy) else $error("write accepted during response");
    property p_rbusy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_rbusy: assert property (p_rbusy) else $error("read accepted during response");
    property p_plain;
        (status_plain & ~$past(status_in)) == '0;
    endproperty
    a_plain: assert property (p_plain) else $error("plain input high without input");
    property p_three;
        (!model_six && !$past(model_six)) |-> coil_circuit_failure_flag[5:3] == 3'h0;
    endproperty
    a_three: assert property (p_three) else $error("absent coil flagged");
endmodule
bind ccs_top ccs_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_ccs_monitor (
    .aclk(aclk), .aresetn(aresetn), .model_six(model_six), .status_in(status_in),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .coil_circuit_failure_flag(coil_circuit_failure_flag),
    .coil_event(coil_event), .test_pulse(test_pulse), .status_plain(status_plain)
);
`default_nettype wire

// >>> ccs_breaker_model.sv
// Behavioural breaker contacts and coil wiring seen through the status inputs
`timescale 1ns/1ps
`default_nettype none
module ccs_breaker_model (
    input wire logic supply_ok,
    input wire logic [ccs_pkg::NUM_COILS-1:0] closed,
    input wire logic [ccs_pkg::NUM_COILS-1:0] broken,
    input wire logic [ccs_pkg::NUM_INPUTS-1:0] plain,
    output logic [ccs_pkg::NUM_INPUTS-1:0] status_in
);
    import ccs_pkg::*;
    // First input sees the open-position contact, second the closed-position one
    always_comb begin
        status_in = plain;
        for (int i = 0; i < NUM_COILS; i++) begin
            status_in[PAIR_A[i]] = supply_ok & ~closed[i] & ~broken[i];
            status_in[PAIR_B[i]] = supply_ok & closed[i] & ~broken[i];
        end
    end
endmodule
`default_nettype wire

// >>> ccs_top_tb.sv
// Self-checking bench for the coil circuit supervisor
`timescale 1ns/1ps
`default_nettype none
module ccs_top_tb;
    import ccs_pkg::*;
    localparam int TK = 4;
    localparam int SEC = PERIOD_TICKS * TK;
    localparam logic [31:0] CFG_DEF = 32'(DLY_RST) << CFG_DLY_LSB;
    logic aclk, aresetn, model_six, supply_ok, test_pulse;
    logic [NUM_COILS-1:0] closed, broken, flag, evt;
    logic [NUM_INPUTS-1:0] plain, status_in, status_plain;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int bad_count, checks_done, n;
    ccs_breaker_model u_far (.supply_ok(supply_ok), .closed(closed), .broken(broken),
        .plain(plain), .status_in(status_in));
    ccs_top #(.TICK_CYCLES(TK)) DUT (.aclk(aclk), .aresetn(aresetn), .model_six(model_six),
        .status_in(status_in), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .coil_circuit_failure_flag(flag), .coil_event(evt), .test_pulse(test_pulse),
        .status_plain(status_plain));
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask
    // Ready follows valid, so every response is stalled one cycle on purpose
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && !bready) bready <= 1'b1;
        end while (!(bvalid && bready) && k < 100);
        bready <= 1'b0;
        chk(k < 100 && bresp === er, "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            k++;
            if (arready) arvalid <= 1'b0;
            if (rvalid && !rready) rready <= 1'b1;
        end while (!(rvalid && rready) && k < 100);
        rready <= 1'b0;
        d = (k < 100) ? rdata : 32'hx;
        r = rresp;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        axi_rd(a);
        chk((d & m) === e && r === RESP_OKAY, "register read");
    endtask
    task automatic cfg(input int i, input logic [1:0] m, input logic [12:0] dl);
        axi_wr(REG_CFG0 + 8'(4 * i), (32'(dl) << CFG_DLY_LSB) | 32'(m), RESP_OKAY);
    endtask
    task automatic wait_flag(input int i, input logic v, input int lim);
        n = 0;
        while (flag[i] !== v && n < lim) begin
            @(posedge aclk);
            n++;
        end
    endtask
    task automatic wait_tp(input logic v);
        wait_flag(0, flag[0], 0);
        while (test_pulse !== v && n < 2 * SEC) begin
            @(posedge aclk);
            n++;
        end
        chk(n < 2 * SEC, "test pulse missing");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic do_reset(input logic six);
        aresetn <= 1'b0;
        model_six <= six;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        $display("ERROR %0t run hung", $time);
        final_report();
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = '0;
        {closed, broken} = '0;
        supply_ok = 1'b1;
        plain = 22'h3fffff;
        do_reset(1'b1);
        for (int i = 0; i < NUM_COILS; i++) rd_chk(REG_CFG0 + 8'(4 * i), '1, CFG_DEF);
        rd_chk(REG_STATUS, 32'h3f | (32'h1 << ST_MODEL_BIT), 32'h1 << ST_MODEL_BIT);
        axi_rd(8'h80);
        chk(r === RESP_SLVERR, "unmapped read");
        axi_wr(8'h13, 32'h2, RESP_SLVERR);
        axi_wr(REG_STATUS, 32'h3f, RESP_OKAY);
        rd_chk(REG_CFG0, '1, CFG_DEF);
        cfg(0, MODE_TWO, 2);
        cfg(1, MODE_ONE, 2);
        cfg(2, MODE_TWO, 120);
        cfg(3, 2'h3, 2);
        rd_chk(REG_CFG0 + 8'h04, '1, 32'h0201);
        rd_chk(REG_INPUTS, 32'h3fffff, 32'(status_in));
        // Inputs 3,4,6,9,10 are taken by supervision; coil 4 in mode 3 leaves 17,18 plain
        chk(status_plain === (status_in & ~22'h00032c), "plain inputs");
        repeat (SEC + 50) @(posedge aclk);
        chk(flag === 6'h00, "healthy open breaker");
        // Recloser stand-in: never close coil 1 onto a failed trip circuit
        closed <= 6'h03 & ~6'(flag[0]);
        repeat (2 * SEC) @(posedge aclk);
        chk(flag === 6'h02, "closed breaker per mode");
        rd_chk(REG_EVENT, 32'h3f, 32'h02);
        axi_wr(REG_EVENT, 32'h3f, RESP_OKAY);
        rd_chk(REG_EVENT, 32'h3f, 32'h00);
        closed <= 6'h00;
        wait_flag(1, 1'b0, SEC + 10);
        chk(n < SEC + 10 && test_pulse === 1'b1, "clear at sample");
        wait_tp(1'b0);
        broken <= 6'h05;
        wait_tp(1'b1);
        wait_flag(0, 1'b1, 2 * SEC);
        chk(n >= 11 * TK - 2 && n <= 11 * TK + 2, "failure delay");
        chk(evt === 6'h01, "event pulse on flag rise");
        broken <= 6'h00;
        wait_flag(0, 1'b0, SEC + 10);
        chk(n < SEC + 10 && flag[2] === 1'b0, "short discordance");
        cfg(2, MODE_TWO, 2);
        supply_ok <= 1'b0;
        repeat (2 * SEC) @(posedge aclk);
        chk(flag === 6'h07, "supply loss");
        rd_chk(REG_STATUS, 32'h3f, 32'h07);
        cfg(0, MODE_NONE, 2);
        cfg(1, 2'h3, 2);
        repeat (2) @(posedge aclk);
        chk(flag === 6'h04, "disabled coils");
        do_reset(1'b0);
        cfg(3, MODE_TWO, 2);
        cfg(0, MODE_TWO, 2);
        repeat (2 * SEC) @(posedge aclk);
        chk(flag === 6'h01, "three coil model");
        rd_chk(REG_STATUS, 32'h1 << ST_MODEL_BIT, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
